// file: rtl/sic_interlock.sv
// Behaviour
// RULE1: power-to-unlock: command high releases lock, low keeps locked.
// RULE2: power-to-lock: command high engages lock, low releases.
// RULE3: standard variant: channels off as soon as lock released.
// RULE4: actuator still inserted: relock re-enables channels without opening guard.
// RULE5: door-open variant: channels off only when guard opens.
// RULE6: green shows supply, yellow operating condition, red error flash codes.
// RULE7: internal error kills channels; cleared by guard open then close.
// RULE8: multiple channel faults or cross-short: lockout cleared only by reset; code locks out only once escalation period has passed.
// RULE9: warning drives diagnostic low, channels stay on; clears by itself.
// RULE10: warning lasting escalation period also switches channels off.
// RULE11: diagnostic high only guard closed, actuator in, no block, warning, error.
// RULE12: closed, inserted, locked: channels on, yellow steady, red off.
// RULE13: locking blocked: yellow flashes, standard off, door-open on, diagnostic low.
// RULE14: channel a or b warning: one or two red pulses, escalates.
// RULE15: cross-short or both channels: three pulses; over-temperature: four pulses.
// RULE16: bad actuator five pulses, bad combination six, channels off immediately.
// RULE17: internal defect or supply fault: red steady, channels off at once.
// RULE18: teach-in: green off, red on, yellow flashes 1 Hz, outputs low.
// RULE19: repeat-teach variant: enabling inhibited ten minutes, green flashing meanwhile.
// RULE20: red codes are pulse bursts plus longer pause, repeating, prescaled.
// RULE21: escalation counter restarts when no warning, requests shutdown at terminal.
`timescale 1ns/1ps
`include "sic_params.svh"
module sic_interlock
  import sic_pkg::*;
#(
  parameter longint ESC_CYC     = `SIC_MIN_CYC(`SIC_ESC_MIN),
  parameter longint INHIBIT_CYC = `SIC_MIN_CYC(`SIC_INHIBIT_MIN),
  parameter longint BLINK_CYC   = `SIC_CLK_HZ / (2 * `SIC_TEACH_BLINK_HZ),
  parameter longint PULSE_CYC   = `SIC_MS_CYC(`SIC_FLASH_PULSE_MS),
  parameter longint PAUSE_CYC   = `SIC_MS_CYC(`SIC_FLASH_PAUSE_MS)
) (
  input  wire logic           MCLK_I,          // system clock
  input  wire logic           RSTN_I,          // power-on reset, active low
  input  wire logic           MAGNET_CMD_I,    // solenoid command from controller
  input  wire logic           POWER_TO_LOCK_I, // 1: power-to-lock variant
  input  wire logic           DOOR_OPEN_VAR_I, // 1: door-open channel variant
  input  wire logic           REPEAT_TEACH_I,  // repeat_teach_variant
  input  wire logic           GUARD_CLOSED_I,  // guard closed sensor
  input  wire logic           ACT_INSERTED_I,  // actuator in detection range
  input  wire logic           BOLT_LOCKED_I,   // bolt reached locked position
  input  wire logic           TEACH_ACTIVE_I,  // teach-in in progress
  input  wire logic           TEACH_DONE_I,    // pulse: new actuator learned
  input  wire sic_faults_type FAULTS_I,        // fault conditions
  output logic                LOCK_DRIVE_O,    // solenoid drive, 1 = lock
  output logic                SAFETY_CHANNEL_A_O, // safety_channel_a
  output logic                SAFETY_CHANNEL_B_O, // safety_channel_b
  output logic                DIAG_O,          // conventional diagnostic output
  output sic_leds_type        LEDS_O,          // green, yellow, red
  output logic [2:0]          FLASH_CODE_O,    // active red code, 7 = steady
  output logic                LOCKOUT_O        // latched lockout
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  sic_state_type st_reg, st_next;
  logic [63:0]   esc_cnt_reg, esc_cnt_next;
  logic          esc_trip_reg, esc_trip_next;
  logic [63:0]   inh_cnt_reg, inh_cnt_next;
  logic          inh_reg, inh_next;
  logic          seen_open_reg, seen_open_next;
  logic [63:0]   blink_cnt_reg, blink_cnt_next;
  logic          blink_reg, blink_next;
  logic [63:0]   fl_cnt_reg, fl_cnt_next;
  logic [3:0]    fl_step_reg, fl_step_next;
  logic          fl_pause_reg, fl_pause_next;
  logic          lock_o_reg, ch_o_reg, diag_o_reg, lockout_o_reg;
  sic_leds_type  leds_o_reg;
  logic [2:0]    code_o_reg;
  logic          lock_next, ch_next, diag_next, lockout_next;
  sic_leds_type  leds_next;
  logic [2:0]    code_next;

  logic warn, immediate, locked, blocked;
  logic [3:0] fl_last;
  logic [2:0] code;

  // ----------------------------------------
  // fault classification
  // ----------------------------------------
  always_comb begin
    warn      = FAULTS_I.chan_a_warn | FAULTS_I.chan_b_warn
              | FAULTS_I.cross_short | FAULTS_I.over_temp;       // [RULE9]
    immediate = FAULTS_I.bad_actuator | FAULTS_I.bad_combo
              | FAULTS_I.internal_err | FAULTS_I.supply_err;     // [RULE16] [RULE17]
    code      = 3'h0;
    if (FAULTS_I.internal_err | FAULTS_I.supply_err) begin
      code = 3'h7;                                              // [RULE17]
    end else if (FAULTS_I.bad_combo) begin
      code = 3'h6;                                              // [RULE16]
    end else if (FAULTS_I.bad_actuator) begin
      code = 3'h5;                                              // [RULE16]
    end else if (FAULTS_I.cross_short | (FAULTS_I.chan_a_warn & FAULTS_I.chan_b_warn)) begin
      code = 3'h3;                                              // [RULE15]
    end else if (FAULTS_I.over_temp) begin
      code = 3'h4;                                              // [RULE15]
    end else if (FAULTS_I.chan_b_warn) begin
      code = 3'h2;                                              // [RULE14]
    end else if (FAULTS_I.chan_a_warn) begin
      code = 3'h1;                                              // [RULE14]
    end
  end

  // ----------------------------------------
  // control state and timers
  // ----------------------------------------
  always_comb begin
    st_next        = st_reg;
    seen_open_next = seen_open_reg;
    // escalation timer
    esc_cnt_next  = esc_cnt_reg;
    esc_trip_next = esc_trip_reg;
    if (!warn) begin
      esc_cnt_next  = 64'h0000_0000_0000_0000;                  // [RULE21]
      esc_trip_next = 1'b0;
    end else if (esc_cnt_reg >= 64'(ESC_CYC - 1)) begin
      esc_trip_next = 1'b1;                                     // [RULE10] [RULE21]
    end else begin
      esc_cnt_next = esc_cnt_reg + 64'h0000_0000_0000_0001;
    end
    // enabling inhibit after new actuator
    inh_cnt_next = inh_cnt_reg;
    inh_next     = inh_reg;
    if (TEACH_DONE_I && REPEAT_TEACH_I) begin
      inh_next     = 1'b1;                                      // [RULE19]
      inh_cnt_next = 64'h0000_0000_0000_0000;
    end else if (inh_reg) begin
      if (inh_cnt_reg >= 64'(INHIBIT_CYC - 1)) begin
        if (ACT_INSERTED_I) begin
          inh_next = 1'b0;                                      // [RULE19]
        end
      end else begin
        inh_cnt_next = inh_cnt_reg + 64'h0000_0000_0000_0001;
      end
    end
    // state transitions: teach-in, error entry and clear, lockout hold
    case (st_reg)
      SIC_ST_RUN: begin
        if (TEACH_ACTIVE_I) begin
          st_next = SIC_ST_TEACH;
        end else if (immediate) begin
          st_next        = SIC_ST_ERROR;                        // [RULE7]
          seen_open_next = 1'b0;
        end
      end
      SIC_ST_ERROR: begin
        if (!GUARD_CLOSED_I) begin
          seen_open_next = 1'b1;
        end else if (seen_open_reg && !immediate) begin
          st_next = SIC_ST_RUN;                                 // [RULE7]
        end
      end
      SIC_ST_TEACH: begin
        if (!TEACH_ACTIVE_I) begin
          st_next = SIC_ST_RUN;
        end
      end
      SIC_ST_LOCKOUT: st_next = SIC_ST_LOCKOUT;                 // [RULE8]
      default: st_next = SIC_ST_RUN;
    endcase
    // escalated cross-short forces lockout from any state
    if ((FAULTS_I.cross_short | (FAULTS_I.chan_a_warn & FAULTS_I.chan_b_warn)) && esc_trip_reg) begin
      st_next = SIC_ST_LOCKOUT;                                 // [RULE8]
    end
  end

  // ----------------------------------------
  // blink and flash code sequencer
  // ----------------------------------------
  always_comb begin
    blink_cnt_next = blink_cnt_reg + 64'h0000_0000_0000_0001;
    blink_next     = blink_reg;
    if (blink_cnt_reg >= 64'(BLINK_CYC - 1)) begin
      blink_cnt_next = 64'h0000_0000_0000_0000;
      blink_next     = ~blink_reg;                              // [RULE18]
    end
    // steps: even = pulse on, odd = gap; after 2*code steps a long pause
    // burst of n pulses ends on gap step 2n-1
    fl_last       = {code, 1'b0} - 4'h1;
    fl_cnt_next   = fl_cnt_reg + 64'h0000_0000_0000_0001;
    fl_step_next  = fl_step_reg;
    fl_pause_next = fl_pause_reg;
    if (code == 3'h0 || code == 3'h7) begin
      fl_cnt_next   = 64'h0000_0000_0000_0000;
      fl_step_next  = 4'h0;
      fl_pause_next = 1'b0;
    end else if (fl_pause_reg) begin
      if (fl_cnt_reg >= 64'(PAUSE_CYC - 1)) begin
        fl_cnt_next   = 64'h0000_0000_0000_0000;
        fl_pause_next = 1'b0;                                   // [RULE20]
      end
    end else if (fl_cnt_reg >= 64'(PULSE_CYC - 1)) begin
      fl_cnt_next = 64'h0000_0000_0000_0000;
      if (fl_step_reg == fl_last) begin
        fl_step_next  = 4'h0;
        fl_pause_next = 1'b1;                                   // [RULE20]
      end else begin
        fl_step_next = fl_step_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    lock_next    = POWER_TO_LOCK_I ? MAGNET_CMD_I : ~MAGNET_CMD_I;  // [RULE1] [RULE2]
    locked       = lock_next & BOLT_LOCKED_I;
    blocked      = lock_next & ~BOLT_LOCKED_I;
    ch_next      = 1'b0;
    diag_next    = 1'b0;
    leds_next    = '{green: 1'b1, yellow: 1'b0, red: 1'b0};     // [RULE6]
    code_next    = code;
    lockout_next = (st_reg == SIC_ST_LOCKOUT);
    case (st_reg)
      SIC_ST_RUN: begin
        if (GUARD_CLOSED_I && ACT_INSERTED_I && !inh_reg) begin
          if (locked) begin
            ch_next          = 1'b1;                            // [RULE12] [RULE4]
            leds_next.yellow = 1'b1;
          end else begin
            ch_next          = DOOR_OPEN_VAR_I;                 // [RULE3] [RULE5] [RULE13]
            leds_next.yellow = blink_reg;
          end
          // fresh hard fault or teach-in must not leave diagnostic high
          diag_next = ~blocked & ~warn & ~immediate & ~TEACH_ACTIVE_I;  // [RULE11] [RULE13] [RULE9] [RULE18]
        end
        if (esc_trip_reg | immediate) begin
          ch_next = 1'b0;                                       // [RULE10] [RULE16]
        end
        if (inh_reg) begin
          leds_next.green = blink_reg;                          // [RULE19]
        end
        if (warn) begin
          leds_next.red = ~fl_pause_reg & ~fl_step_reg[0];      // [RULE14] [RULE15]
        end
      end
      SIC_ST_TEACH: begin
        leds_next = '{green: 1'b0, yellow: blink_reg, red: 1'b1};  // [RULE18]
      end
      default: begin
        // error or lockout: channels off, red code or steady
        leds_next.red = (code == 3'h7) | (code != 3'h0 && !fl_pause_reg && !fl_step_reg[0]);  // [RULE17] [RULE20]
        // lockout shows cross-short code unless a fault has its own
        if (st_reg == SIC_ST_LOCKOUT && code == 3'h0) begin
          code_next = 3'h3;                                     // [RULE8]
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_reg        <= SIC_ST_RUN;
      esc_cnt_reg   <= 64'h0000_0000_0000_0000;
      esc_trip_reg  <= 1'b0;
      inh_cnt_reg   <= 64'h0000_0000_0000_0000;
      inh_reg       <= 1'b0;
      seen_open_reg <= 1'b0;
      blink_cnt_reg <= 64'h0000_0000_0000_0000;
      blink_reg     <= 1'b0;
      fl_cnt_reg    <= 64'h0000_0000_0000_0000;
      fl_step_reg   <= 4'h0;
      fl_pause_reg  <= 1'b0;
      lock_o_reg    <= 1'b0;
      ch_o_reg      <= 1'b0;
      diag_o_reg    <= 1'b0;
      lockout_o_reg <= 1'b0;
      leds_o_reg    <= '{green: 1'b0, yellow: 1'b0, red: 1'b0};
      code_o_reg    <= `SIC_RST_CODE;
    end else begin
      st_reg        <= st_next;
      esc_cnt_reg   <= esc_cnt_next;
      esc_trip_reg  <= esc_trip_next;
      inh_cnt_reg   <= inh_cnt_next;
      inh_reg       <= inh_next;
      seen_open_reg <= seen_open_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
      fl_cnt_reg    <= fl_cnt_next;
      fl_step_reg   <= fl_step_next;
      fl_pause_reg  <= fl_pause_next;
      lock_o_reg    <= lock_next;
      ch_o_reg      <= ch_next;
      diag_o_reg    <= diag_next;
      lockout_o_reg <= lockout_next;
      leds_o_reg    <= leds_next;
      code_o_reg    <= code_next;
    end
  end

  assign LOCK_DRIVE_O       = lock_o_reg;
  assign SAFETY_CHANNEL_A_O = ch_o_reg;
  assign SAFETY_CHANNEL_B_O = ch_o_reg;
  assign DIAG_O             = diag_o_reg;
  assign LEDS_O             = leds_o_reg;
  assign FLASH_CODE_O       = code_o_reg;
  assign LOCKOUT_O          = lockout_o_reg;

endmodule : sic_interlock

// file: rtl/sic_params.svh
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SIC_CLK_HZ          250000000
`define SIC_ESC_MIN         30
`define SIC_INHIBIT_MIN     10
`define SIC_TEACH_BLINK_HZ  1
`define SIC_FLASH_PULSE_MS  200
`define SIC_FLASH_PAUSE_MS  1200
`define SIC_MIN_CYC(m)      (64'd60 * (m) * `SIC_CLK_HZ)
`define SIC_MS_CYC(ms)      (64'd1 * (ms) * (`SIC_CLK_HZ / 1000))
// ----------------------------------------
// reset values
// ----------------------------------------
`define SIC_RST_CODE        3'h0
`endif

// file: rtl/sic_pkg.sv
package sic_pkg;
  // fault inputs reported by the diagnostics front end
  typedef struct packed {
    logic chan_a_warn;
    logic chan_b_warn;
    logic cross_short;
    logic over_temp;
    logic bad_actuator;
    logic bad_combo;
    logic internal_err;
    logic supply_err;
  } sic_faults_type;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } sic_leds_type;

  typedef enum logic [1:0] {
    SIC_ST_RUN     = 2'b00,
    SIC_ST_ERROR   = 2'b01,
    SIC_ST_LOCKOUT = 2'b10,
    SIC_ST_TEACH   = 2'b11
  } sic_state_type;
endpackage : sic_pkg

// file: verif/sic_interlock_monitor.sv
`timescale 1ns/1ps
module sic_interlock_monitor
  import sic_pkg::*;
#(
  parameter longint ESC_CYC = 400
) (
  input wire logic           MCLK_I,             // clock
  input wire logic           RSTN_I,             // reset, active low
  input wire logic           MAGNET_CMD_I,       // solenoid command
  input wire logic           POWER_TO_LOCK_I,    // lock polarity
  input wire logic           DOOR_OPEN_VAR_I,    // channel variant
  input wire logic           GUARD_CLOSED_I,     // guard closed
  input wire logic           ACT_INSERTED_I,     // actuator in
  input wire logic           BOLT_LOCKED_I,      // bolt locked
  input wire logic           TEACH_ACTIVE_I,     // teach-in
  input wire sic_faults_type FAULTS_I,           // faults
  input wire logic           LOCK_DRIVE_O,       // lock drive
  input wire logic           SAFETY_CHANNEL_A_O, // channel a
  input wire logic           SAFETY_CHANNEL_B_O, // channel b
  input wire logic           DIAG_O,             // diagnostic
  input wire sic_leds_type   LEDS_O,             // leds
  input wire logic [2:0]     FLASH_CODE_O,       // red code
  input wire logic           LOCKOUT_O           // lockout
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------
  // run length of any warning
  // ----------------------------------------
  logic [31:0] warn_run_reg;
  logic [31:0] warn_run_next;
  always_comb begin
    warn_run_next = (|FAULTS_I[7:4]) ? warn_run_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) warn_run_reg <= 32'h0000_0000;
    else warn_run_reg <= warn_run_next;
  end
  a_chan_pair: assert property (SAFETY_CHANNEL_A_O == SAFETY_CHANNEL_B_O)
    else $error("channels differ");
  a_lock_polarity: assert property ($past(RSTN_I) |-> LOCK_DRIVE_O == $past(MAGNET_CMD_I ~^ POWER_TO_LOCK_I))
    else $error("lock drive wrong polarity");
  a_guard_open: assert property (!GUARD_CLOSED_I [*2] |=> !SAFETY_CHANNEL_A_O && !DIAG_O)
    else $error("outputs on with guard open");
  a_std_unlock: assert property ((!DOOR_OPEN_VAR_I && !BOLT_LOCKED_I) [*2] |=> !SAFETY_CHANNEL_A_O)
    else $error("standard channels on while unlocked");
  a_diag_cause: assert property ($past(RSTN_I) && DIAG_O |->
    $past(GUARD_CLOSED_I && ACT_INSERTED_I && FAULTS_I == 8'h00 && !TEACH_ACTIVE_I))
    else $error("diagnostic high without cause");
  a_fast_off: assert property (FAULTS_I[3:0] != 4'h0 |-> ##2 !SAFETY_CHANNEL_A_O)
    else $error("channels on after hard fault");
  a_steady_red: assert property ((FAULTS_I.internal_err || FAULTS_I.supply_err) [*3] |=>
    FLASH_CODE_O == 3'h7 && LEDS_O.red)
    else $error("red not steady");
  a_red_pulse: assert property ($fell(LEDS_O.red) && FLASH_CODE_O inside {[1:6]} && $past(FLASH_CODE_O, 4) == FLASH_CODE_O
    |-> $past(LEDS_O.red, 3) && !$past(LEDS_O.red, 4))
    else $error("red pulse width wrong");
  a_lockout_hold: assert property (LOCKOUT_O |=> LOCKOUT_O && !SAFETY_CHANNEL_A_O)
    else $error("lockout left or channels on");
  a_teach_dark: assert property (TEACH_ACTIVE_I [*2] |=>
    !LEDS_O.green && LEDS_O.red && !SAFETY_CHANNEL_A_O && !DIAG_O)
    else $error("teach indication wrong");
  a_warn_escalate: assert property (warn_run_reg > ESC_CYC + 3 |-> !SAFETY_CHANNEL_A_O)
    else $error("warning not escalated");
  c_lockout: cover property ($rose(LOCKOUT_O));
  c_code_six: cover property (FLASH_CODE_O == 3'h6);
  c_escalate: cover property (warn_run_reg == ESC_CYC + 4);
endmodule : sic_interlock_monitor

bind sic_interlock sic_interlock_monitor #(.ESC_CYC(ESC_CYC)) i_sic_interlock_monitor (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .MAGNET_CMD_I(MAGNET_CMD_I), .POWER_TO_LOCK_I(POWER_TO_LOCK_I),
  .DOOR_OPEN_VAR_I(DOOR_OPEN_VAR_I), .GUARD_CLOSED_I(GUARD_CLOSED_I), .ACT_INSERTED_I(ACT_INSERTED_I),
  .BOLT_LOCKED_I(BOLT_LOCKED_I), .TEACH_ACTIVE_I(TEACH_ACTIVE_I), .FAULTS_I(FAULTS_I), .LOCK_DRIVE_O(LOCK_DRIVE_O),
  .SAFETY_CHANNEL_A_O(SAFETY_CHANNEL_A_O), .SAFETY_CHANNEL_B_O(SAFETY_CHANNEL_B_O), .DIAG_O(DIAG_O),
  .LEDS_O(LEDS_O), .FLASH_CODE_O(FLASH_CODE_O), .LOCKOUT_O(LOCKOUT_O)
);

// file: verif/sic_plc_model.sv
`timescale 1ns/1ps
module sic_plc_model (
  input  wire logic clk_i,           // clock
  input  wire logic rstn_i,          // reset, active low
  input  wire logic want_lock_i,     // lock wanted
  input  wire logic power_to_lock_i, // lock polarity
  input  wire logic chan_a_i,        // channel a
  input  wire logic chan_b_i,        // channel b
  output logic      magnet_cmd_o,    // solenoid command
  output logic      enabled_o        // both channels on
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      magnet_cmd_o <= 1'b0;
      enabled_o    <= 1'b0;
    end else begin
      magnet_cmd_o <= power_to_lock_i ? want_lock_i : !want_lock_i;
      enabled_o    <= chan_a_i & chan_b_i;
    end
  end
endmodule : sic_plc_model

// file: verif/sic_interlock_bench.sv
`timescale 1ns/1ps
module sic_interlock_bench;
  import sic_pkg::*;
  localparam int ESC = 400;
  localparam int INH = 100;
  logic           mclk = 1'b0, rstn = 1'b0, want = 1'b1, ptl = 1'b0, dov = 1'b0, rpt = 1'b1;
  logic           guard = 1'b1, act = 1'b1, bolt = 1'b1, teach = 1'b0, tdone = 1'b0;
  sic_faults_type faults = '0;
  logic           cmd, lock_drv, ch_a, ch_b, diag, lockout, ok;
  sic_leds_type   leds;
  logic [2:0]     code;
  int             mismatches = 0, samples_checked = 0, cycles = 0, n;
  logic [7:0]     pat [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'hC0};
  logic [7:0]     exp_code [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h07, 8'h03};
  always #2 mclk = ~mclk;
  sic_plc_model i_sic_plc_model (.clk_i(mclk), .rstn_i(rstn), .want_lock_i(want), .power_to_lock_i(ptl),
    .chan_a_i(ch_a), .chan_b_i(ch_b), .magnet_cmd_o(cmd), .enabled_o(ok));
  sic_interlock #(.ESC_CYC(ESC), .INHIBIT_CYC(INH), .BLINK_CYC(4), .PULSE_CYC(3), .PAUSE_CYC(10)) i_sic_interlock (
    .MCLK_I(mclk), .RSTN_I(rstn), .MAGNET_CMD_I(cmd), .POWER_TO_LOCK_I(ptl), .DOOR_OPEN_VAR_I(dov),
    .REPEAT_TEACH_I(rpt), .GUARD_CLOSED_I(guard), .ACT_INSERTED_I(act), .BOLT_LOCKED_I(bolt),
    .TEACH_ACTIVE_I(teach), .TEACH_DONE_I(tdone), .FAULTS_I(faults), .LOCK_DRIVE_O(lock_drv),
    .SAFETY_CHANNEL_A_O(ch_a), .SAFETY_CHANNEL_B_O(ch_b), .DIAG_O(diag), .LEDS_O(leds),
    .FLASH_CODE_O(code), .LOCKOUT_O(lockout));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wt(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : wt
  task automatic count_red(input int len, output int cnt);
    logic prev;
    cnt = 0;
    prev = leds.red;
    repeat (len) begin
      wt(1);
      if (leds.red === 1'b1 && prev === 1'b0) cnt++;
      prev = leds.red;
    end
  endtask : count_red
  task automatic reopen();
    @(posedge mclk);
    guard <= 1'b0;
    act <= 1'b0;
    wt(4);
    check("open_outputs", {ch_a, diag}, 8'h00);
    @(posedge mclk);
    guard <= 1'b1;
    act <= 1'b1;
    wt(6);
  endtask : reopen
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    wt(6);
    for (int v = 0; v < 4; v++) begin
      @(posedge mclk);
      ptl <= v[0];
      dov <= v[1];
      wt(6);
      check("lock_drive", lock_drv, 8'h01);
      check("locked_outputs", {ch_a, ch_b, ok, diag}, 8'h0F);
      check("locked_leds", leds, 8'h06);
      @(posedge mclk);
      want <= 1'b0;
      bolt <= 1'b0;
      wt(6);
      check("unlock_drive", lock_drv, 8'h00);
      check("unlock_outputs", {ch_a, diag}, {dov, 1'b1});
      @(posedge mclk);
      want <= 1'b1;
      wt(6);
      check("blocked_outputs", {ch_a, diag}, {dov, 1'b0});
      @(posedge mclk);
      bolt <= 1'b1;
      wt(6);
      check("relock_chan", ch_a, 8'h01);
      reopen();
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      faults <= pat[i];
      wt(30);
      check("flash_code", code, exp_code[i]);
      check("fault_chan", ch_a, (i < 4 || i == 8));
      check("fault_diag", diag, 8'h00);
      if (exp_code[i] < 8'h07) begin
        count_red(exp_code[i] * 6 + 10, n);
        check("red_pulses", n[7:0], exp_code[i]);
      end else
        check("red_steady", leds.red, 8'h01);
      @(posedge mclk);
      faults <= '0;
      wt(4);
      check("cleared_chan", ch_a, (i < 4 || i == 8));
      reopen();
      check("reopened", {ch_a, code}, 8'h08);
    end
    @(posedge mclk);
    faults <= 8'h10;
    wt(ESC - 20);
    check("pre_trip_chan", ch_a, 8'h01);
    wt(40);
    check("trip_chan_code", {ch_a, code}, 8'h04);
    @(posedge mclk);
    faults <= 8'h20;
    wt(ESC + 40);
    @(posedge mclk);
    faults <= '0;
    reopen();
    check("lockout_held", {lockout, ch_a}, 8'h02);
    @(posedge mclk);
    rstn <= 1'b0;
    wt(3);
    @(posedge mclk);
    rstn <= 1'b1;
    wt(6);
    check("lockout_reset", {lockout, ch_a}, 8'h01);
    @(posedge mclk);
    teach <= 1'b1;
    wt(6);
    check("teach_out", {leds.green, leds.red, ch_a, diag}, 8'h04);
    @(posedge mclk);
    teach <= 1'b0;
    tdone <= 1'b1;
    @(posedge mclk);
    tdone <= 1'b0;
    wt(INH / 2);
    check("inhibit_chan", ch_a, 8'h00);
    wt(INH);
    check("inhibit_done", ch_a, 8'h01);
    @(posedge mclk);
    rpt <= 1'b0;
    tdone <= 1'b1;
    @(posedge mclk);
    tdone <= 1'b0;
    wt(10);
    check("single_teach_no_inhibit", {ch_a, leds.green}, 8'h03);
    summarize();
  end
endmodule : sic_interlock_bench
